/* cce_exec.sv */
module cce_exec (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire cce_pkg::cce_req_t req,
  output logic ready,
  output cce_pkg::cce_cmd_t cmd,
  output cce_pkg::cce_pre_t last_pre
);
  import cce_pkg::*;

  cce_state_t state_q, state_d;
  cce_pre_t pre_q, pre_d;
  cce_cmd_t cmd_q, cmd_d;
  logic ready_q, ready_d;
  logic [PC_W-1:0] tgt_q, tgt_d;
  logic take;

  assign take = req.valid && ready_q;
  assign ready = ready_q;
  assign cmd = cmd_q;
  assign last_pre = pre_q;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing and command decode
  always_comb begin
    state_d = state_q;
    ready_d = ready_q;
    tgt_d = tgt_q;
    cmd_d = CMD_IDLE;
    unique case (state_q)
      ST_IDLE: begin
        if (take) begin
          unique case (req.op)
            OP_CALL: begin
              cmd_d.push = 1'b1;
              cmd_d.ret_addr = req.pc + PC_STEP;
              tgt_d = req.target;
              state_d = ST_CALL2;
              ready_d = 1'b0;
            end
            OP_BYTE_CLR: begin
              cmd_d.mem_we = 1'b1;
              cmd_d.mem_addr = req.maddr;
              cmd_d.mem_wdata = BYTE_ZERO;
            end
            OP_BIT_CLR: begin
              cmd_d.mem_we = 1'b1;
              cmd_d.mem_addr = req.maddr;
              cmd_d.mem_wdata = req.mrd & ~(BIT_ONE << req.bit_sel);
            end
            OP_WDT_CLR: begin
              cmd_d.wdt_clr = 1'b1;
              cmd_d.to_clr = 1'b1;
              cmd_d.pdf_clr = 1'b1;
            end
            OP_WDT_PRE1, OP_WDT_PRE2: begin
              if ((req.op == OP_WDT_PRE1 && pre_q == PRE_SECOND) ||
                  (req.op == OP_WDT_PRE2 && pre_q == PRE_FIRST)) begin
                cmd_d.wdt_clr = 1'b1;
                cmd_d.to_clr = 1'b1;
                cmd_d.pdf_clr = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_CALL2: begin
        cmd_d.pc_load = 1'b1;
        cmd_d.pc_target = tgt_q;
        state_d = ST_IDLE;
        ready_d = 1'b1;
      end
      default: begin
        state_d = ST_IDLE;
        ready_d = 1'b1;
      end
    endcase
    // flag clears come only from the watchdog ops here
    // call and memory clears drive only push, pc and memory fields; the
    // to_clr and pdf_clr flag clears are raised only by watchdog clears and completed pre-clear pairs
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      ready_q <= 1'b1;
      tgt_q <= '0;
      cmd_q <= CMD_IDLE;
    end else begin
      state_q <= state_d;
      ready_q <= ready_d;
      tgt_q <= tgt_d;
      cmd_q <= cmd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pre-clear alternation tracker
  always_comb begin
    pre_d = pre_q;
    if (take && req.op == OP_WDT_PRE1) begin
      // repeats only re-arm the first half
      pre_d = (pre_q == PRE_SECOND) ? PRE_NONE : PRE_FIRST;
    end else if (take && req.op == OP_WDT_PRE2) begin
      pre_d = (pre_q == PRE_FIRST) ? PRE_NONE : PRE_SECOND;
    end
  end

  // a completed pair returns to none so that a third pre-clear cannot ride on it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= PRE_NONE;
    end else begin
      pre_q <= pre_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  call_push_a: assert property (take && req.op == OP_CALL |=>
    cmd_q.push && cmd_q.ret_addr == $past(req.pc) + PC_STEP)
    else $error("call did not push pc plus one");

  call_jump_a: assert property (take && req.op == OP_CALL |=>
    ##1 cmd_q.pc_load && cmd_q.pc_target == $past(req.target, 2))
    else $error("call did not load target after push");

  call_busy_a: assert property (take && req.op == OP_CALL |=>
    !ready_q ##1 ready_q && !cmd_q.push)
    else $error("call did not take two cycles");

  no_flag_a: assert property ((cmd_q.push || cmd_q.mem_we || cmd_q.pc_load) |->
    !cmd_q.to_clr && !cmd_q.pdf_clr)
    else $error("flag touched by call or memory clear");

  byte_zero_a: assert property (take && req.op == OP_BYTE_CLR |=>
    cmd_q.mem_we && cmd_q.mem_wdata == BYTE_ZERO && cmd_q.mem_addr == $past(req.maddr))
    else $error("byte clear wrote nonzero");

  bit_keep_a: assert property (take && req.op == OP_BIT_CLR |=>
    cmd_q.mem_we && !cmd_q.mem_wdata[$past(req.bit_sel)] &&
    ((cmd_q.mem_wdata ^ $past(req.mrd)) & ~(BIT_ONE << $past(req.bit_sel))) == BYTE_ZERO)
    else $error("bit clear disturbed other bits");

  wdt_clr_a: assert property (take && req.op == OP_WDT_CLR |=>
    cmd_q.wdt_clr && cmd_q.to_clr && cmd_q.pdf_clr)
    else $error("watchdog clear missed");

  pre_pair_a: assert property (take && req.op == OP_WDT_PRE1 && pre_q == PRE_SECOND |=>
    cmd_q.wdt_clr && cmd_q.to_clr && cmd_q.pdf_clr)
    else $error("alternated first pre-clear had no effect");

  pre_repeat_a: assert property (take && req.op == OP_WDT_PRE1 ##1
    take && req.op == OP_WDT_PRE1 |=> !cmd_q.wdt_clr && !cmd_q.to_clr)
    else $error("repeated first pre-clear had effect");

  pre_second_a: assert property (take && req.op == OP_WDT_PRE2 |=>
    cmd_q.wdt_clr == ($past(pre_q) == PRE_FIRST))
    else $error("second pre-clear alternation wrong");

  pre_track_a: assert property (take && req.op == OP_WDT_PRE2 && pre_q != PRE_FIRST |=>
    pre_q == PRE_SECOND)
    else $error("last pre-clear not remembered");

  ////////////////////////////////////////////////////////////////////////////
  // side effects: each op must leave the other command fields quiet

  ret_clean_a: assert property (!cmd_q.push |->
    cmd_q.ret_addr == '0)
    else $error("return address shown without push");

  gap_ignore_a: assert property (!ready_q && req.valid |=>
    !cmd_q.push && !cmd_q.mem_we && !cmd_q.wdt_clr)
    else $error("request in call gap was acted on");

  gap_once_a: assert property (!ready_q |=>
    ready_q)
    else $error("ready stayed low more than one cycle");

  call_quiet_a: assert property (take && req.op == OP_CALL |=>
    !cmd_q.wdt_clr && !cmd_q.to_clr && !cmd_q.pdf_clr && !cmd_q.mem_we)
    else $error("call raised a flag or memory write");

  clr_quiet_a: assert property (take && (req.op == OP_BYTE_CLR || req.op == OP_BIT_CLR) |=>
    !cmd_q.to_clr && !cmd_q.pdf_clr && !cmd_q.push && !cmd_q.pc_load)
    else $error("memory clear raised a flag or jump");

  wdt_keep_a: assert property (take && req.op == OP_WDT_CLR |=>
    !cmd_q.mem_we && !cmd_q.push && pre_q == $past(pre_q))
    else $error("watchdog clear disturbed other state");

  pre_lone_a: assert property (take && req.op == OP_WDT_PRE1 && pre_q != PRE_SECOND |=>
    !cmd_q.wdt_clr && !cmd_q.to_clr && !cmd_q.pdf_clr)
    else $error("unpaired first pre-clear had effect");

  pre2_repeat_a: assert property (take && req.op == OP_WDT_PRE2 ##1
    take && req.op == OP_WDT_PRE2 |=> !cmd_q.wdt_clr && !cmd_q.pdf_clr)
    else $error("repeated second pre-clear had effect");

  pre_first_a: assert property (take && req.op == OP_WDT_PRE1 && pre_q != PRE_SECOND |=>
    pre_q == PRE_FIRST)
    else $error("first pre-clear not remembered");

  pair_done_a: assert property (take && req.op == OP_WDT_PRE2 && pre_q == PRE_FIRST |=>
    pre_q == PRE_NONE)
    else $error("completed pair left tracker armed");

  // scenario covers: call, bit clear, pair, single clear, repeated first half
  call_c: cover property (take && req.op == OP_CALL ##2 cmd_q.pc_load);
  bit_c: cover property (take && req.op == OP_BIT_CLR);
  pair_c: cover property (take && req.op == OP_WDT_PRE1 ##[1:4] take && req.op == OP_WDT_PRE2);
  wdt_c: cover property (take && req.op == OP_WDT_CLR);
  rep_c: cover property (take && req.op == OP_WDT_PRE1 ##1 take && req.op == OP_WDT_PRE1);

endmodule

/* cce_pkg.sv */
package cce_pkg;

  localparam int PC_W = 13;
  localparam int MA_W = 8;
  localparam int DW = 8;
  localparam int BI_W = 3;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  localparam logic [DW-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DW-1:0] BIT_ONE = 8'h01;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_CALL = 3'b001,
    OP_BYTE_CLR = 3'b010,
    OP_BIT_CLR = 3'b011,
    OP_WDT_CLR = 3'b100,
    OP_WDT_PRE1 = 3'b101,
    OP_WDT_PRE2 = 3'b110
  } cce_op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CALL2 = 1'b1
  } cce_state_t;

  typedef enum logic [1:0] {
    PRE_NONE = 2'b00,
    PRE_FIRST = 2'b01,
    PRE_SECOND = 2'b10
  } cce_pre_t;

  // one decoded instruction from fetch/decode, with the operand byte already read
  typedef struct packed {
    logic valid;
    cce_op_t op;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] target;
    logic [MA_W-1:0] maddr;
    logic [BI_W-1:0] bit_sel;
    logic [DW-1:0] mrd;
  } cce_req_t;

  // commands to program counter, stack, data memory and watchdog
  typedef struct packed {
    logic push;
    logic [PC_W-1:0] ret_addr;
    logic pc_load;
    logic [PC_W-1:0] pc_target;
    logic mem_we;
    logic [MA_W-1:0] mem_addr;
    logic [DW-1:0] mem_wdata;
    logic wdt_clr;
    logic to_clr;
    logic pdf_clr;
  } cce_cmd_t;

  localparam cce_cmd_t CMD_IDLE = '0;

endpackage

/* tb_top.sv */
module tb_top import cce_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    cce_op_t op;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] tgt;
    logic [MA_W-1:0] ma;
    logic [BI_W-1:0] bs;
    logic [DW-1:0] mrd;
    cce_cmd_t c;
    cce_pre_t p;
  } cce_row_t;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  cce_req_t req = '0;
  logic ready;
  cce_cmd_t cmd;
  cce_pre_t last_pre;
  int n_fail = 0;
  int n_tests = 0;
  cce_row_t rows [6];
  ////////////////////////////////////////////////////////////////////////////////
  // free-running core clock, 10 ns period
  always #5 ref_clk = ~ref_clk;
  cce_exec uut (.ref_clk(ref_clk), .rstn(rstn), .req(req), .ready(ready), .cmd(cmd),
    .last_pre(last_pre));
  ////////////////////////////////////////////////////////////////////////////////
  // widened compare so one task serves every output field
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic cce_cmd_t f_mem(input logic [MA_W-1:0] a, input logic [DW-1:0] d);
    f_mem = CMD_IDLE;
    f_mem.mem_we = 1'b1;
    f_mem.mem_addr = a;
    f_mem.mem_wdata = d;
  endfunction
  function automatic cce_cmd_t f_wdt();
    f_wdt = CMD_IDLE;
    f_wdt.wdt_clr = 1'b1;
    f_wdt.to_clr = 1'b1;
    f_wdt.pdf_clr = 1'b1;
  endfunction
  // row with an opcode only; address and data fields stay zero
  function automatic cce_row_t rp(input cce_op_t op, input cce_cmd_t c, input cce_pre_t p);
    rp = '{op, '0, '0, '0, '0, '0, c, p};
  endfunction
  // drive at the falling edge, judge the pulse one falling edge later
  task automatic step(input cce_row_t r, input logic rdy);
    req = '{1'b1, r.op, r.pc, r.tgt, r.ma, r.bs, r.mrd};
    @(negedge ref_clk);
    chk(64'(cmd), 64'(r.c)); // whole command, no stray flag
    chk(64'(last_pre), 64'(r.p)); // pre-clear tracker
    chk(64'(ready), 64'(rdy)); // ready gap
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: reset, table of plain ops, then call and pre-clear corners
  initial begin
    rows[0] = '{OP_BYTE_CLR, '0, '0, 8'h3c, 3'h0, 8'ha5, f_mem(8'h3c, 8'h00), PRE_NONE};
    rows[1] = '{OP_BIT_CLR, '0, '0, 8'h10, 3'h0, 8'hff, f_mem(8'h10, 8'hfe), PRE_NONE};
    rows[2] = '{OP_BIT_CLR, '0, '0, 8'hff, 3'h7, 8'hff, f_mem(8'hff, 8'h7f), PRE_NONE};
    rows[3] = '{OP_BIT_CLR, '0, '0, 8'h00, 3'h3, 8'h08, f_mem(8'h00, 8'h00), PRE_NONE};
    rows[4] = rp(OP_WDT_CLR, f_wdt(), PRE_NONE);
    rows[5] = rp(OP_NONE, CMD_IDLE, PRE_NONE);
    repeat (15) @(negedge ref_clk);
    chk(64'(ready), 64'h1);
    chk(64'(cmd), 64'h0);
    chk(64'(last_pre), 64'h0);
    @(negedge ref_clk);
    rstn = 1'b1;
    foreach (rows[i]) begin
      step(rows[i], 1'b1);
    end
    // return address wraps at the top of program space
    step('{OP_CALL, 13'h1fff, 13'h0123, '0, '0, '0,
      '{1'b1, 13'h0000, 1'b0, '0, 1'b0, '0, '0, 1'b0, 1'b0, 1'b0}, PRE_NONE}, 1'b0);
    // a request in the gap cycle must vanish without trace
    step('{OP_BYTE_CLR, '0, '0, 8'h55, '0, '0,
      '{1'b0, '0, 1'b1, 13'h0123, 1'b0, '0, '0, 1'b0, 1'b0, 1'b0}, PRE_NONE}, 1'b1);
    step(rp(OP_NONE, CMD_IDLE, PRE_NONE), 1'b1);
    step(rp(OP_WDT_PRE1, CMD_IDLE, PRE_FIRST), 1'b1);
    step(rp(OP_WDT_PRE1, CMD_IDLE, PRE_FIRST), 1'b1);
    step(rp(OP_WDT_PRE2, f_wdt(), PRE_NONE), 1'b1);
    step(rp(OP_WDT_PRE2, CMD_IDLE, PRE_SECOND), 1'b1);
    step(rp(OP_WDT_PRE2, CMD_IDLE, PRE_SECOND), 1'b1);
    step(rp(OP_WDT_PRE1, f_wdt(), PRE_NONE), 1'b1);
    step(rp(OP_WDT_PRE1, CMD_IDLE, PRE_FIRST), 1'b1);
    step(rp(OP_WDT_CLR, f_wdt(), PRE_FIRST), 1'b1);
    step(rp(OP_WDT_PRE2, f_wdt(), PRE_NONE), 1'b1);
    step(rp(OP_WDT_PRE1, CMD_IDLE, PRE_FIRST), 1'b1);
    // reset in mid-pair forgets the half-done alternation
    req = '0;
    rstn = 1'b0;
    @(negedge ref_clk);
    chk(64'(last_pre), 64'h0);
    rstn = 1'b1;
    step(rp(OP_WDT_PRE2, CMD_IDLE, PRE_SECOND), 1'b1);
    req = '0;
    @(negedge ref_clk);
    print_verdict();
  end
  // watchdog: the whole run needs well under a microsecond
  initial begin
    #20000;
    n_fail++;
    print_verdict();
  end
endmodule
